/* rtl/sier_eval_lock.sv */
// Notes on behaviour
// - Network switching signals select monitoring case.
// - Complementary input needs two inverse channels.
// - High/low decodes 0; low/high decodes 1.
// - Inversion checked on every input in complementary mode.
// - Equal channels force outputs OFF, flag error.
// - One-of-n: exactly one channel high.
// - Single high channel selects cases 1..4.
// - Field interruption drives output OFF.
// - OFF held at least 80 ms.
// - Per-output interlock, enabled by configuration.
// - Reset request arrives from network party.
// - Interlocked output stays OFF after field clears.
// - Interlocked output returns ON only on reset.
// - Reset ignored while field still interrupted.
// - Reset refused while any fault present.
`timescale 1ns/1ns
`default_nettype none
`include "sier_map.svh"

module sier_eval_lock
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RST,
  // Control inputs and configuration from the network side.
  input wire sier_pkg::sier_ctrl_t CTRL_IN,
  input wire sier_pkg::sier_eval_t EVAL_MODE,
  input wire logic [`SIER_NOUT-1:0] INTERLOCK_EN,
  input wire logic [`SIER_NOUT-1:0] RESET_REQ,
  // Scanner status.
  input wire logic [`SIER_NOUT-1:0] FIELD_INTERRUPTED,
  input wire logic DEVICE_FAULT,
  // Results.
  output logic [`SIER_NOUT-1:0] SAFETY_OUT,
  output logic INPUT_ERROR,
  output logic [2:0] MONITOR_CASE,
  output logic [1:0] COMPL_STATE
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************

  // The hold length follows from the clock rate and is not a parameter.
  // A simulation that wants an output back ON must run the full minimum OFF time.
  // The counter is wider than needed, so a faster clock still fits without a change.
  localparam int unsigned HOLD_CYC = `SIER_MIN_OFF_CYC;
  localparam int NOUT = `SIER_NOUT;

  logic [3:0] ctrl_s1;
  logic [3:0] ctrl_s2;
  logic [NOUT-1:0] rst_s1;
  logic [NOUT-1:0] rst_s2;
  logic [NOUT-1:0] fld_s1;
  logic [NOUT-1:0] fld_s2;
  logic flt_s1;
  logic flt_s2;
  logic mode_s1;
  logic mode_s2;
  logic [NOUT-1:0] ilk_s1;
  logic [NOUT-1:0] ilk_s2;

  // Every network or pin level passes two flops before it is read.
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_s1 <= 4'h0;
      ctrl_s2 <= 4'h0;
      rst_s1 <= '0;
      rst_s2 <= '0;
      fld_s1 <= '1;
      fld_s2 <= '1;
      flt_s1 <= 1'h1;
      flt_s2 <= 1'h1;
      mode_s1 <= 1'h0;
      mode_s2 <= 1'h0;
      ilk_s1 <= '1;
      ilk_s2 <= '1;
    end
    else
    begin
      ctrl_s1 <= CTRL_IN;
      ctrl_s2 <= ctrl_s1;
      rst_s1 <= RESET_REQ;
      rst_s2 <= rst_s1;
      fld_s1 <= FIELD_INTERRUPTED;
      fld_s2 <= fld_s1;
      flt_s1 <= DEVICE_FAULT;
      flt_s2 <= flt_s1;
      mode_s1 <= EVAL_MODE;
      mode_s2 <= mode_s1;
      ilk_s1 <= INTERLOCK_EN;
      ilk_s2 <= ilk_s1;
    end
  end

  // ****************************************************************
  // Control input evaluation
  // ****************************************************************

  // A pair is valid only when the channels differ; value is channel two.
  function automatic logic [1:0] sier_compl(input logic one, input logic two);
    sier_compl = {one ^ two, two};
  endfunction : sier_compl

  wire sier_pkg::sier_ctrl_t ctrl = sier_pkg::sier_ctrl_t'(ctrl_s2);
  wire logic [1:0] dec_a = sier_compl(ctrl.input_a.channel_one, ctrl.input_a.channel_two);
  wire logic [1:0] dec_b = sier_compl(ctrl.input_b.channel_one, ctrl.input_b.channel_two);
  // Both pairs are checked whatever case is active, so an unused input still trips.
  wire logic compl_err = !dec_a[1] || !dec_b[1];
  wire logic [3:0] ch = {ctrl.input_a.channel_one, ctrl.input_a.channel_two,
                         ctrl.input_b.channel_one, ctrl.input_b.channel_two};
  wire logic [2:0] onen_case = (ch == 4'h8) ? `SIER_CASE_1 :
                               (ch == 4'h4) ? `SIER_CASE_2 :
                               (ch == 4'h2) ? `SIER_CASE_3 :
                               (ch == 4'h1) ? `SIER_CASE_4 : `SIER_CASE_ERR;
  wire logic onen_err = (onen_case == `SIER_CASE_ERR);
  wire logic is_onen = (mode_s2 == 1'(sier_pkg::SIER_ONE_OF_N));
  wire logic in_err = is_onen ? onen_err : compl_err;
  // Complementary mode presents the two decoded bits as a case index 1..4.
  wire logic [2:0] compl_case = 3'({1'h0, dec_a[0], dec_b[0]} + 3'h1);
  wire logic [2:0] next_case = in_err ? `SIER_CASE_ERR : (is_onen ? onen_case : compl_case);
  // A fault anywhere blocks resets and forces outputs OFF.
  wire logic any_fault = in_err || flt_s2;

  // ****************************************************************
  // Restart interlock per safety output
  // ****************************************************************

  sier_pkg::sier_out_state_t st [NOUT];
  logic [31:0] hold_cnt [NOUT];
  logic [NOUT-1:0] next_out;

  genvar g;
  generate
    for (g = 0; g < NOUT; g++)
    begin : g_out
      wire logic trip = fld_s2[g] || any_fault;
      wire logic hold_done = (hold_cnt[g] >= HOLD_CYC - 1);
      // Reset counts only with a clear field and no fault present.
      wire logic reset_ok = rst_s2[g] && !fld_s2[g] && !any_fault;
      assign next_out[g] = (st[g] == sier_pkg::SIER_ON) && !trip;

      // A new trip during the hold restarts the minimum OFF time.
      always_ff @(posedge SYS_CLK or posedge RST)
      begin
        if (RST)
        begin
          st[g] <= sier_pkg::SIER_HOLD;
          hold_cnt[g] <= 32'h0;
        end
        else
        begin
          unique case (st[g])
            sier_pkg::SIER_ON:
            begin
              hold_cnt[g] <= 32'h0;
              if (trip)
                st[g] <= sier_pkg::SIER_HOLD;
            end
            sier_pkg::SIER_HOLD:
            begin
              if (trip)
                hold_cnt[g] <= 32'h0;
              else if (!hold_done)
                hold_cnt[g] <= hold_cnt[g] + 32'h1;
              else if (ilk_s2[g])
                st[g] <= sier_pkg::SIER_WAIT_RESET;
              else
                st[g] <= sier_pkg::SIER_ON;
            end
            sier_pkg::SIER_WAIT_RESET:
            begin
              if (trip)
              begin
                st[g] <= sier_pkg::SIER_HOLD;
                hold_cnt[g] <= 32'h0;
              end
              else if (reset_ok)
                st[g] <= sier_pkg::SIER_ON;
            end
            default:
              st[g] <= sier_pkg::SIER_HOLD;
          endcase
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Registered outputs
  // ****************************************************************

  // Outputs come straight from flops so no decode glitch reaches the network.
  // The trade is one more cycle of latency between a trip and the OFF level.
  // The complementary decode on COMPL_STATE is shown even in error so that the fault can be traced; MONITOR_CASE shows the error code.
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      SAFETY_OUT <= '0;
      INPUT_ERROR <= 1'h0;
      MONITOR_CASE <= `SIER_CASE_ERR;
      COMPL_STATE <= 2'h0;
    end
    else
    begin
      SAFETY_OUT <= next_out;
      INPUT_ERROR <= in_err;
      MONITOR_CASE <= next_case;
      COMPL_STATE <= {dec_a[0], dec_b[0]};
    end
  end

endmodule : sier_eval_lock
`default_nettype wire

/* rtl/sier_map.svh */
`ifndef SIER_MAP_SVH
`define SIER_MAP_SVH

// ****************************************************************
// Timing and sizes
// ****************************************************************

// Clock rate in kHz and minimum OFF hold in ms.
`define SIER_CLK_KHZ 100000
`define SIER_MIN_OFF_MS 80
// Cycles of minimum OFF hold, derived from the rate.
`define SIER_MIN_OFF_CYC (`SIER_CLK_KHZ * `SIER_MIN_OFF_MS)
// Number of safety outputs.
`define SIER_NOUT 2
// Monitoring case codes in both evaluation modes.
`define SIER_CASE_ERR 3'h0
`define SIER_CASE_1 3'h1
`define SIER_CASE_2 3'h2
`define SIER_CASE_3 3'h3
`define SIER_CASE_4 3'h4

`endif

/* rtl/sier_pkg.sv */
`default_nettype none
package sier_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************

  // Two channel pair of one static control input.
  typedef struct packed {
    logic channel_one;
    logic channel_two;
  } sier_pair_t;

  // Both static control inputs as received from the network.
  typedef struct packed {
    sier_pair_t input_a;
    sier_pair_t input_b;
  } sier_ctrl_t;

  // Evaluation method of the static control inputs.
  typedef enum logic {
    SIER_COMPLEMENTARY,
    SIER_ONE_OF_N
  } sier_eval_t;

  // Restart interlock states of one safety output.
  typedef enum logic [1:0] {
    SIER_ON,
    SIER_HOLD,
    SIER_WAIT_RESET
  } sier_out_state_t;

endpackage : sier_pkg
`default_nettype wire

/* verif/sier_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ***
// Network controller model
// ***
module sier_ctrl_model
(
  // Clock and commands.
  input wire logic clk,
  input wire logic [2:0] sel,
  input wire logic om,
  input wire logic [1:0] rq,
  // Network signals.
  output var sier_pkg::sier_ctrl_t ctrl = 4'h5,
  output var sier_pkg::sier_eval_t mode = sier_pkg::SIER_COMPLEMENTARY,
  output var logic [1:0] rreq = 2'h0
);
  // Sel bit two breaks pair A on purpose; one-of-n code zero sends no channel.
  always @(posedge clk)
  begin
    mode <= om ? sier_pkg::SIER_ONE_OF_N : sier_pkg::SIER_COMPLEMENTARY;
    ctrl <= om ? 4'(5'h10 >> sel) : {~sel[1], sel[1] ^ sel[2], ~sel[0], sel[0]};
    // Only a reset is sent; starting motion stays a separate later command.
    rreq <= rq;
  end
endmodule : sier_ctrl_model
`default_nettype wire

/* verif/sier_eval_lock_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sier_map.svh"
// ***
// Port checker
// ***
module sier_eval_lock_asserts
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RST,
  // Watched ports.
  input wire sier_pkg::sier_ctrl_t CTRL_IN,
  input wire sier_pkg::sier_eval_t EVAL_MODE,
  input wire logic [`SIER_NOUT-1:0] INTERLOCK_EN,
  input wire logic [`SIER_NOUT-1:0] RESET_REQ,
  input wire logic [`SIER_NOUT-1:0] FIELD_INTERRUPTED,
  input wire logic DEVICE_FAULT,
  input wire logic [`SIER_NOUT-1:0] SAFETY_OUT,
  input wire logic INPUT_ERROR,
  input wire logic [2:0] MONITOR_CASE,
  input wire logic [1:0] COMPL_STATE
);
  // Decoded views of the raw channels; both pairs count in every case.
  wire logic onen = EVAL_MODE == sier_pkg::SIER_ONE_OF_N;
  wire logic [3:0] raw = CTRL_IN;
  wire logic c_bad = raw[3] == raw[2] || raw[1] == raw[0];
  wire logic hot = $onehot(raw);
  wire logic [2:0] exp_case = raw[3] ? 3'h1 : raw[2] ? 3'h2 : raw[1] ? 3'h3 : 3'h4;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // Cycles that output zero has spent OFF; it saturates so it never wraps.
  logic [31:0] off_cnt;
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      off_cnt <= 32'h0;
    else if (SAFETY_OUT[0])
      off_cnt <= 32'h0;
    else if (off_cnt != 32'hffffffff)
      off_cnt <= off_cnt + 32'h1;
  end
  // Five steady samples cover the two sync flops and the result register.
  sequence s_cok; (!onen && !c_bad && $stable(raw) && $stable(EVAL_MODE)) [*5]; endsequence
  sequence s_cbad; (!onen && c_bad && $stable(raw) && $stable(EVAL_MODE)) [*5]; endsequence
  sequence s_ohot; (onen && hot && $stable(raw) && $stable(EVAL_MODE)) [*5]; endsequence
  sequence s_obad; (onen && !hot && $stable(raw) && $stable(EVAL_MODE)) [*5]; endsequence
  property p_cdec; s_cok |-> COMPL_STATE == {raw[2], raw[0]} && !INPUT_ERROR; endproperty
  property p_cerr; s_cbad |-> INPUT_ERROR; endproperty
  property p_osel; s_ohot |-> MONITOR_CASE == exp_case && !INPUT_ERROR; endproperty
  property p_oerr; s_obad |-> INPUT_ERROR && MONITOR_CASE == 3'h0; endproperty
  property p_eoff; INPUT_ERROR [*2] |-> SAFETY_OUT == '0; endproperty
  property p_trip; FIELD_INTERRUPTED[0] [*5] |-> !SAFETY_OUT[0]; endproperty
  property p_fault; DEVICE_FAULT [*5] |-> SAFETY_OUT == '0; endproperty
  property p_rej; (RESET_REQ[1] && FIELD_INTERRUPTED[1]) [*5] |-> !SAFETY_OUT[1]; endproperty
  property p_hold; $rose(SAFETY_OUT[0]) |-> off_cnt >= 32'(`SIER_MIN_OFF_CYC); endproperty
  a_cdec: assert property (p_cdec) else $error("bad complementary decode");
  a_cerr: assert property (p_cerr) else $error("equal pair not flagged");
  a_osel: assert property (p_osel) else $error("bad one-of-n case");
  a_oerr: assert property (p_oerr) else $error("one-of-n error missed");
  a_eoff: assert property (p_eoff) else $error("output on with input error");
  a_trip: assert property (p_trip) else $error("output on in field trip");
  a_fault: assert property (p_fault) else $error("output on with fault");
  a_rej: assert property (p_rej) else $error("reset taken in trip");
  a_hold: assert property (p_hold) else $error("output on before minimum off time");
endmodule : sier_eval_lock_asserts
bind sier_eval_lock sier_eval_lock_asserts i_chk (.SYS_CLK(SYS_CLK), .RST(RST),
  .CTRL_IN(CTRL_IN), .EVAL_MODE(EVAL_MODE), .INTERLOCK_EN(INTERLOCK_EN),
  .RESET_REQ(RESET_REQ), .FIELD_INTERRUPTED(FIELD_INTERRUPTED), .DEVICE_FAULT(DEVICE_FAULT),
  .SAFETY_OUT(SAFETY_OUT), .INPUT_ERROR(INPUT_ERROR), .MONITOR_CASE(MONITOR_CASE),
  .COMPL_STATE(COMPL_STATE));
`default_nettype wire

/* verif/tb_sier_eval_lock.sv */
`timescale 1ns/1ns
`default_nettype none
// ***
// Bench
// ***
module tb_sier_eval_lock;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic [2:0] sel = 3'h0;
  logic om = 1'b0;
  logic [1:0] rq = 2'h0;
  logic [1:0] ilk = 2'h1;
  logic [1:0] fld = 2'h0;
  logic flt = 1'b0;
  int err_count = 0;
  int checks = 0;
  sier_pkg::sier_ctrl_t ctrl;
  sier_pkg::sier_eval_t mode;
  logic [1:0] rreq;
  logic [1:0] so;
  logic ie;
  logic [2:0] mc;
  logic [1:0] cs;
  sier_ctrl_model i_ctrl (.clk(SYS_CLK), .sel(sel), .om(om), .rq(rq), .ctrl(ctrl),
    .mode(mode), .rreq(rreq));
  sier_eval_lock i_dut (.SYS_CLK(SYS_CLK), .RST(RST), .CTRL_IN(ctrl), .EVAL_MODE(mode),
    .INTERLOCK_EN(ilk), .RESET_REQ(rreq), .FIELD_INTERRUPTED(fld), .DEVICE_FAULT(flt),
    .SAFETY_OUT(so), .INPUT_ERROR(ie), .MONITOR_CASE(mc), .COMPL_STATE(cs));
  // Free running clock.
  initial
  begin
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // The model adds one edge to the design's three; seven leaves margin.
  task go(input logic [2:0] s, input logic m);
    @(posedge SYS_CLK);
    sel <= s;
    om <= m;
    repeat (7) @(posedge SYS_CLK);
    #1;
  endtask : go
  // Field, fault and reset request; the minimum OFF time outlasts the whole run.
  task drv(input logic [1:0] f, input logic d, input logic [1:0] r);
    @(posedge SYS_CLK);
    fld <= f;
    flt <= d;
    rq <= r;
    repeat (7) @(posedge SYS_CLK);
    #1;
  endtask : drv
  task chk(input logic [3:0] g, input logic [3:0] e);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task t_compl;
    for (int i = 0; i < 4; i++)
    begin
      go(3'(i), 1'b0);
      chk({2'h0, ie, cs[1]}, {3'h0, i[1]});
      chk({3'h0, cs[0]}, {3'h0, i[0]});
      chk({1'b0, mc}, 4'(i + 1));
    end
    go(3'h4, 1'b0);
    chk({1'b0, ie, so}, 4'h4);
    chk({1'b0, mc}, 4'h0);
  endtask : t_compl
  task t_one;
    for (int i = 0; i < 5; i++)
    begin
      go(3'(i), 1'b1);
      chk({ie, mc}, {(i == 0), 3'(i)});
    end
  endtask : t_one
  task t_trip;
    drv(2'h3, 1'b0, 2'h3);
    chk({2'h0, so}, 4'h0);
    drv(2'h0, 1'b1, 2'h3);
    chk({2'h0, so}, 4'h0);
    drv(2'h0, 1'b0, 2'h3);
    chk({2'h0, so}, 4'h0);
  endtask : t_trip
  task results;
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // Outputs are checked while reset is still held, then the scenarios run.
  initial
  begin
    repeat (5) @(posedge SYS_CLK);
    #1;
    chk({ie, mc}, 4'h0);
    chk({so, cs}, 4'h0);
    @(posedge SYS_CLK);
    RST <= 1'b0;
    t_compl();
    t_one();
    go(3'h1, 1'b1);
    t_trip();
    results();
  end
  // The tests need about a hundred cycles; this span is far beyond that.
  initial
  begin
    #20000;
    err_count++;
    results();
  end
endmodule : tb_sier_eval_lock
`default_nettype wire
